//--- src/sos_top.sv
// Behaviour
// - code 197 shows motion paused
// - code 198 shows sequence running
// - code 199 shows wait or dwell
// - code 200 shows latched low event
// - code 201 shows latched high event
// - code 202 shows latched step advance
// - code 203 shows pulse while input disabled
// - code 204 shows direct operation ready
// - code 205 shows direct buffer loaded
// - code 207 toggles on operation number change
// - codes 208-215 echo active operation bits
// - codes 216-223 show per-number completion
// - codes 224-255 show listed information flags
// - six terminals, each with own code
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
module sos_top import sos_pkg::*; (
  input wire logic mclk, // 40 MHz system clock
  input wire logic nrst, // Sync reset, low
  input wire sos_status_t status, // Driver status in
  output logic [NUM_OUT-1:0] general_output_q, // Output terminals
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI aw valid
  output logic s_axi_awready, // AXI aw ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI byte strobes
  input wire logic s_axi_wvalid, // AXI w valid
  output logic s_axi_wready, // AXI w ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI b valid
  input wire logic s_axi_bready, // AXI b ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI ar valid
  output logic s_axi_arready, // AXI ar ready
  output logic [DATA_W-1:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI r valid
  input wire logic s_axi_rready // AXI r ready
);

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------

  // Picks one status source for an assignment code
  function automatic logic sel_source(
    input logic [CODE_W-1:0] code,
    input sos_status_t st,
    input logic [NUM_LAT-1:0] lat,
    input logic tog
  );
    logic r;
    logic [CODE_W-1:0] rel;
    r = 1'b0;
    rel = '0;
    // Ranges first, so the case below sees only single codes
    if (code >= CODE_INFO_BASE) begin
      rel = code - CODE_INFO_BASE;
      r = st.info_flags[rel[4:0]] & INFO_VALID[rel[4:0]];
    end else if (code >= CODE_DONE_BASE) begin
      rel = code - CODE_DONE_BASE;
      r = st.op_done_flags[rel[2:0]];
    end else if (code >= CODE_ACT_BASE) begin
      rel = code - CODE_ACT_BASE;
      r = st.active_op_num[rel[2:0]];
    end else begin
      case (code)
        CODE_PAUSE: r = st.pause_active_flag;
        CODE_SEQ: r = st.sequence_running_flag;
        CODE_WAIT: r = st.wait_interval_flag;
        CODE_LOW_EVT: r = lat[LAT_LOW];
        CODE_HIGH_EVT: r = lat[LAT_HIGH];
        CODE_STEP: r = lat[LAT_STEP];
        CODE_LOST: r = lat[LAT_LOST];
        CODE_DIR_RDY: r = st.direct_op_ready;
        CODE_DIR_FULL: r = st.direct_buffer_loaded;
        CODE_TOGGLE: r = tog;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------

  // Aligned word inside the assignment block
  function automatic logic is_assign_addr(
    input logic [ADDR_W-1:0] a
  );
    return (a[ASSIGN_IDX_LSB-1:0] == '0)
           && (a < REG_LATCH)
           && (a >= REG_ASSIGN_BASE);
  endfunction

  // Terminal number of an assignment word
  function automatic logic [ASSIGN_IDX_W-1:0] assign_idx(
    input logic [ADDR_W-1:0] a
  );
    return a[ASSIGN_IDX_LSB +: ASSIGN_IDX_W];
  endfunction

  // Words that answer OKAY; the status word ignores writes
  function automatic logic is_mapped(
    input logic [ADDR_W-1:0] a
  );
    return is_assign_addr(a) || (a == REG_LATCH) || (a == REG_OUT_STAT);
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------

  // Handshakes stay in the slave; only a one-cycle strobe leaves it
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_ok;
  logic rd_ok;

  sos_axil_slave u_bus (
    .mclk(mclk),
    .nrst(nrst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready_q(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready_q(s_axi_wready),
    .bresp_q(s_axi_bresp),
    .bvalid_q(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready_q(s_axi_arready),
    .rdata_q(s_axi_rdata),
    .rresp_q(s_axi_rresp),
    .rvalid_q(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr_q(wr_addr),
    .wr_data_q(wr_data),
    .wr_strb_q(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr_q(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  logic [CODE_W-1:0] assign_q [NUM_OUT];
  logic [NUM_LAT-1:0] lat_q;
  logic [ASSIGN_IDX_W-1:0] wr_idx;
  logic [ASSIGN_IDX_W-1:0] rd_idx;
  logic wr_is_assign;
  logic rd_is_assign;
  logic wr_is_latch;
  logic rd_is_latch;
  logic rd_is_stat;
  logic [NUM_LAT-1:0] lat_clr;
  logic wr_low_byte;

  // Assignment words occupy the first six aligned words
  assign wr_idx = assign_idx(wr_addr);
  assign rd_idx = assign_idx(rd_addr);
  assign wr_is_assign = is_assign_addr(wr_addr);
  assign rd_is_assign = is_assign_addr(rd_addr);
  assign wr_is_latch = (wr_addr == REG_LATCH);
  assign rd_is_latch = (rd_addr == REG_LATCH);
  assign rd_is_stat = (rd_addr == REG_OUT_STAT);

  // Unmapped words answer SLVERR and read as zero
  assign wr_ok = is_mapped(wr_addr);
  assign rd_ok = is_mapped(rd_addr);

  // Only the low byte carries a code or a clear mask
  assign wr_low_byte = wr_en & wr_strb[0];

  // Write-one-to-clear on latch word; a same-cycle set still wins
  assign lat_clr = (wr_low_byte && wr_is_latch)
                   ? wr_data[NUM_LAT-1:0] : '0;

  // Address is held by the slave, so the mux settles a cycle early
  // Read mux, upper bits zero
  assign rd_data = rd_is_assign
                   ? {{(DATA_W-CODE_W){1'b0}}, assign_q[rd_idx]}
                   : rd_is_latch
                   ? {{(DATA_W-NUM_LAT){1'b0}}, lat_q}
                   : rd_is_stat
                   ? {{(DATA_W-NUM_OUT){1'b0}}, general_output_q}
                   : '0;

  // ----------------------------------------------------------------
  // Assignment registers
  // ----------------------------------------------------------------

  // Unlisted codes are stored and simply select nothing
  // one code per terminal
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        assign_q[i] <= ASSIGN_RST;
      end
    end else if (wr_low_byte && wr_is_assign) begin
      assign_q[wr_idx] <= wr_data[CODE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Event latches
  // ----------------------------------------------------------------

  logic [NUM_LAT-1:0] lat_set;

  // Lost pulses latch too, so a slow host never misses one
  // pulse arriving with input disabled
  assign lat_set = {status.cmd_pulse & ~status.pulse_input_en,
                    status.step_advance_pulse,
                    status.high_event_pulse,
                    status.low_event_pulse};

  sos_event_latch #(
    .N(NUM_LAT)
  ) u_lat (
    .mclk(mclk),
    .nrst(nrst),
    .set(lat_set),
    .clr(lat_clr),
    .lat_q(lat_q)
  );

  // ----------------------------------------------------------------
  // Operation number toggle
  // ----------------------------------------------------------------

  logic [7:0] prev_num_q;
  logic tog_q;
  logic num_chg;

  assign num_chg = (status.active_op_num != prev_num_q);

  // Compared with the last sample; nonzero at release flips once
  // invert on each change
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prev_num_q <= '0;
      tog_q <= 1'b0;
    end else begin
      prev_num_q <= status.active_op_num;
      tog_q <= tog_q ^ num_chg;
    end
  end

  // ----------------------------------------------------------------
  // Output terminals
  // ----------------------------------------------------------------

  logic [NUM_OUT-1:0] out_d;

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      out_d[i] = sel_source(assign_q[i], status, lat_q, tog_q);
    end
  end

  // Terminals lag their source by one edge
  // Registered so terminals never glitch on a code change
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      general_output_q <= '0;
    end else begin
      general_output_q <= out_d;
    end
  end

endmodule // sos_top

//--- src/sos_pkg.sv
package sos_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 6;
  localparam int CODE_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_LAT = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_ASSIGN_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LATCH = 8'h18;
  localparam logic [ADDR_W-1:0] REG_OUT_STAT = 8'h1C;
  localparam int ASSIGN_IDX_LSB = 2;
  localparam int ASSIGN_IDX_W = 3;
  localparam logic [CODE_W-1:0] ASSIGN_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Assignment codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_PAUSE = 8'hC5;
  localparam logic [CODE_W-1:0] CODE_SEQ = 8'hC6;
  localparam logic [CODE_W-1:0] CODE_WAIT = 8'hC7;
  localparam logic [CODE_W-1:0] CODE_LOW_EVT = 8'hC8;
  localparam logic [CODE_W-1:0] CODE_HIGH_EVT = 8'hC9;
  localparam logic [CODE_W-1:0] CODE_STEP = 8'hCA;
  localparam logic [CODE_W-1:0] CODE_LOST = 8'hCB;
  localparam logic [CODE_W-1:0] CODE_DIR_RDY = 8'hCC;
  localparam logic [CODE_W-1:0] CODE_DIR_FULL = 8'hCD;
  localparam logic [CODE_W-1:0] CODE_TOGGLE = 8'hCF;
  localparam logic [CODE_W-1:0] CODE_ACT_BASE = 8'hD0;
  localparam logic [CODE_W-1:0] CODE_DONE_BASE = 8'hD8;
  localparam logic [CODE_W-1:0] CODE_INFO_BASE = 8'hE0;
  // Information codes that exist (bit n = code 224+n)
  localparam logic [31:0] INFO_VALID = 32'hF03FEF7F;

  // Latch slots
  localparam int LAT_LOW = 0;
  localparam int LAT_HIGH = 1;
  localparam int LAT_STEP = 2;
  localparam int LAT_LOST = 3;

  // ----------------------------------------------------------------
  // Status carried in from the driver core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pause_active_flag;
    logic sequence_running_flag;
    logic wait_interval_flag;
    logic low_event_pulse;
    logic high_event_pulse;
    logic step_advance_pulse;
    logic cmd_pulse;
    logic pulse_input_en;
    logic direct_op_ready;
    logic direct_buffer_loaded;
    logic [7:0] active_op_num;
    logic [7:0] op_done_flags;
    logic [31:0] info_flags;
  } sos_status_t;

endpackage

//--- src/sos_event_latch.sv
`timescale 1ns/100ps
module sos_event_latch import sos_pkg::*; #(
  parameter int N = NUM_LAT
) (
  input wire logic mclk, // System clock
  input wire logic nrst, // Sync reset, low
  input wire logic [N-1:0] set, // Event pulses
  input wire logic [N-1:0] clr, // Clear pulses
  output logic [N-1:0] lat_q // Latched events
);

  logic [N-1:0] lat_d;

  // Set beats clear so a same-cycle event is kept
  assign lat_d = (lat_q & ~clr) | set;

  // Latches, cleared by reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      lat_q <= '0;
    end else begin
      lat_q <= lat_d;
    end
  end

endmodule // sos_event_latch

//--- src/sos_axil_slave.sv
`timescale 1ns/100ps
module sos_axil_slave import sos_pkg::*; (
  input wire logic mclk, // System clock
  input wire logic nrst, // Sync reset, low
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready_q, // Write address ready
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready_q, // Write data ready
  output logic [1:0] bresp_q, // Write response
  output logic bvalid_q, // Response valid
  input wire logic bready, // Response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready_q, // Read address ready
  output logic [DATA_W-1:0] rdata_q, // Read data
  output logic [1:0] rresp_q, // Read response
  output logic rvalid_q, // Read valid
  input wire logic rready, // Read ready
  output logic wr_en, // Write strobe, one cycle
  output logic [ADDR_W-1:0] wr_addr_q, // Write address held
  output logic [DATA_W-1:0] wr_data_q, // Write data held
  output logic [3:0] wr_strb_q, // Strobes held
  input wire logic wr_ok, // Address is mapped
  output logic [ADDR_W-1:0] rd_addr_q, // Read address held
  input wire logic [DATA_W-1:0] rd_data, // Read data from top
  input wire logic rd_ok // Address is mapped
);

  logic rd_pend_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;

  // Handshakes and the write issue point
  assign aw_hs = awvalid & awready_q;
  assign w_hs = wvalid & wready_q;
  assign ar_hs = arvalid & arready_q;
  assign wr_en = ~awready_q & ~wready_q & ~bvalid_q;

  // Write channel: address and data in any order, then respond
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        wr_addr_q <= awaddr;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wr_data_q <= wdata;
        wr_strb_q <= wstrb;
      end
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel: one cycle to look up, then hold until taken
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arready_q <= 1'b1;
      rd_pend_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      rd_addr_q <= '0;
    end else begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rd_pend_q <= 1'b1;
        rd_addr_q <= araddr;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_ok ? rd_data : '0;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

endmodule // sos_axil_slave

//--- bench/sos_top_properties.sv
`timescale 1ns/100ps
module sos_checker import sos_pkg::*; (
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset, low
  input wire sos_status_t status, // Status in
  input wire logic [NUM_OUT-1:0] general_output_q, // Terminals
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Aw valid
  input wire logic s_axi_awready, // Aw ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Strobes
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_arvalid, // Ar valid
  input wire logic s_axi_arready, // Ar ready
  input wire logic s_axi_rvalid // R valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [7:0] a_q, d_q, sh_q;
  logic s_q;
  logic [2:0] age_q;
  sos_status_t p1_q, p2_q, p3_q;
  wire ok;
  wire o;
  // Shadow trusted once settled and with no write landing
  assign ok = (age_q > 3'h3) && !s_axi_bvalid;
  assign o = general_output_q[0];
  // Status history for latency-exact checks
  always_ff @(posedge mclk) begin
    p1_q <= status;
    p2_q <= p1_q;
    p3_q <= p2_q;
  end
  // Shadow of terminal 0 code, one edge behind the design
  always_ff @(posedge mclk) begin
    if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) s_q <= s_axi_wstrb[0];
    if (!nrst) begin
      sh_q <= 8'h00;
      age_q <= 3'h0;
    end else if ($rose(s_axi_bvalid) && a_q == 8'h00 && s_q) begin
      sh_q <= d_q;
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  sequence s_wr;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  property p_rst;
    $rose(nrst) |-> general_output_q == 6'h00 && !s_axi_bvalid;
  endproperty
  property p_pause;
    ok && sh_q == 8'hC5 |-> o == $past(status.pause_active_flag);
  endproperty
  property p_wait;
    ok && sh_q == 8'hC7 |-> o == p1_q.wait_interval_flag;
  endproperty
  property p_low;
    ok && sh_q == 8'hC8 && p2_q.low_event_pulse |-> o;
  endproperty
  property p_tog;
    ok && sh_q == 8'hCF
      |-> (o != $past(o)) == (p2_q.active_op_num != p3_q.active_op_num);
  endproperty
  property p_act;
    ok && sh_q[7:3] == 5'h1A |-> o == p1_q.active_op_num[sh_q[2:0]];
  endproperty
  property p_done;
    ok && sh_q[7:3] == 5'h1B |-> o == p1_q.op_done_flags[sh_q[2:0]];
  endproperty
  property p_info;
    ok && sh_q[7:5] == 3'h7
      |-> o == (p1_q.info_flags[sh_q[4:0]] && INFO_VALID[sh_q[4:0]]);
  endproperty
  property p_none;
    ok && (sh_q < 8'hC5 || sh_q == 8'hCE) |-> !o [*2];
  endproperty
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_wr;
  endproperty
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  a_pause: assert property (p_pause) else $error("pause wrong");
  a_wait: assert property (p_wait) else $error("wait wrong");
  a_low: assert property (p_low) else $error("low latch wrong");
  a_tog: assert property (p_tog) else $error("toggle wrong");
  a_act: assert property (p_act) else $error("echo wrong");
  a_done: assert property (p_done) else $error("done wrong");
  a_info: assert property (p_info) else $error("info wrong");
  a_none: assert property (p_none) else $error("unlisted active");
  a_wr: assert property (p_wr) else $error("write timing");
  a_rd: assert property (p_rd) else $error("read timing");
endmodule // sos_checker

bind sos_top sos_checker sos_checker_inst (.mclk, .nrst, .status,
  .general_output_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

//--- bench/sos_host_model.sv
`timescale 1ns/100ps
module sos_host_model import sos_pkg::*; (
  input wire logic mclk, // Clock
  input wire logic [NUM_OUT-1:0] terms, // Terminals seen
  output logic [NUM_OUT-1:0] seen_q // Last sampled levels
);
  // Host samples the terminals once per clock
  always_ff @(posedge mclk) begin
    seen_q <= terms;
  end
endmodule // sos_host_model

//--- bench/tb.sv
`timescale 1ns/100ps
module tb import sos_pkg::*; ();
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  sos_status_t status = '0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] terms, seen;
  logic [33:0] q[$];
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] seed = 32'd8312;
  logic [3:0] lat = 4'h0;
  logic tog = 1'b0;
  logic [7:0] code [6];
  // Codes 231, 236 and 246..251 are absent from the list
  localparam logic [31:0] LISTED = 32'hF03FEF7F;

  // Free-running 40 MHz clock
  always #12.5 mclk = ~mclk;

  sos_top sos_top_inst (.mclk(mclk), .nrst(nrst), .status(status),
    .general_output_q(terms), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sos_host_model sos_host_model_inst (.mclk(mclk), .terms(terms),
    .seen_q(seen));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected terminal level for one code
  function automatic logic src(input logic [7:0] c);
    if (c >= 8'hE0) return LISTED[c[4:0]] & status.info_flags[c[4:0]];
    if (c >= 8'hD8) return status.op_done_flags[c[2:0]];
    if (c >= 8'hD0) return status.active_op_num[c[2:0]];
    case (c)
      8'hC5: return status.pause_active_flag;
      8'hC6: return status.sequence_running_flag;
      8'hC7: return status.wait_interval_flag;
      8'hC8, 8'hC9, 8'hCA, 8'hCB: return lat[c[1:0]];
      8'hCC: return status.direct_op_ready;
      8'hCD: return status.direct_buffer_loaded;
      8'hCF: return tog;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [33:0] t_exp();
    logic [33:0] e;
    e = '0;
    for (int i = 0; i < 6; i++) e[i] = src(code[i]);
    return e;
  endfunction

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ga, gw;
    q.push_back({r, 32'h0});
    ga = 1'b0;
    gw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge mclk);
      if (!ga && awready) begin
        ga = 1'b1;
        awvalid <= 1'b0;
      end
      if (!gw && wready) begin
        gw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Status change keeps the toggle model in step
  task automatic set_st(input sos_status_t s);
    if (s.active_op_num != status.active_op_num) tog = ~tog;
    status <= s;
    @(posedge mclk);
  endtask

  task automatic pulse(input int k);
    sos_status_t s;
    s = status;
    s.low_event_pulse = (k == 0);
    s.high_event_pulse = (k == 1);
    s.step_advance_pulse = (k == 2);
    s.cmd_pulse = (k == 3);
    status <= s;
    @(posedge mclk);
    status <= s & ~58'h0780000_0000_0000;
    @(posedge mclk);
  endtask

  // Result monitor: oldest note against each bus answer
  always @(posedge mclk) begin
    logic [33:0] e;
    if (bvalid && bready) check({bresp, 32'h0}, q.pop_front());
    if (rvalid && rready) begin
      e = q.pop_front();
      check({rresp, rdata}, e);
      // Host's view of the terminals against the same note
      if (araddr == REG_OUT_STAT) check({28'h0, seen}, {28'h0, e[5:0]});
    end
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    sos_status_t s;
    for (int i = 0; i < 6; i++) code[i] = 8'h00;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 34'h0);
    rd(8'h40, {2'h2, 32'h0});
    wr(8'h24, 32'h1, 2'h2);
    for (int n = 0; n < 120; n++) begin
      for (int i = 0; i < 6; i++) begin
        seed = xs(seed);
        code[i] = (i == 0) ? 8'(196 + n % 60) : 8'(196 + seed % 60);
        wr(8'(i * 4), {24'h0, code[i]}, 2'h0);
      end
      seed = xs(seed);
      s = {seed[25:0], xs(seed)};
      seed = xs(seed);
      s = s & ~58'h0780000_0000_0000;
      set_st(s);
      repeat (3) @(posedge mclk);
      rd(8'h1C, t_exp());
    end
    code = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCF, 8'hCE};
    for (int i = 0; i < 6; i++) wr(8'(i * 4), {24'h0, code[i]}, 2'h0);
    s = status;
    s.pulse_input_en = 1'b1;
    set_st(s);
    pulse(3);
    pulse(0);
    lat = 4'h1;
    rd(8'h18, {30'h0, lat});
    rd(8'h1C, t_exp());
    s.pulse_input_en = 1'b0;
    set_st(s);
    for (int k = 3; k > 0; k--) pulse(k);
    lat = 4'hF;
    rd(8'h1C, t_exp());
    wr(8'h18, 32'h5, 2'h0);
    lat = 4'hA;
    rd(8'h18, {30'h0, lat});
    wr(8'h1C, 32'h3F, 2'h0);
    rd(8'h1C, t_exp());
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    lat = 4'h0;
    tog = (status.active_op_num != 8'h00);
    rd(8'h18, 34'h0);
    rd(8'h1C, 34'h0);
    wr(8'h00, 32'hCF, 2'h0);
    code = '{8'hCF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(8'h1C, t_exp());
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule // tb
